// File: rtl/acsc_pkg.sv
/*
  acsc_pkg: register offsets, field positions, reset values, shared types
  for the alarm clamp and shutdown control block.
  assumes an apb slave with 32-bit data, one word per register.
*/
package acsc_pkg;
    localparam logic [7:0] ACSC_OFF_ALARM_CFG = 8'h00;
    localparam logic [7:0] ACSC_OFF_SHUTDOWN = 8'h04;
    localparam logic [7:0] ACSC_OFF_FLAGS = 8'h08;
    localparam logic [7:0] ACSC_OFF_MON_CTRL = 8'h0c;
    localparam int ACSC_B_AVERAGE_MONITOR_EN = 10;
    localparam int ACSC_B_DIE2 = 9;
    localparam int ACSC_B_COMP = 8;
    localparam int ACSC_B_HYST = 6;
    localparam int ACSC_B_CLMP2 = 4;
    localparam int ACSC_B_CLMP1 = 2;
    localparam int ACSC_B_POL = 1;
    localparam int ACSC_B_OPEN = 0;
    localparam logic [15:0] ACSC_CFG_RESET = 16'h0000;
    localparam logic [10:0] ACSC_CFG_MASK = 11'h7ff;
    localparam logic [5:0] ACSC_SHUT_RESET = 6'h00;
    localparam int ACSC_S_FULL_POWER_DOWN = 5;
    localparam int ACSC_S_FORCE_REFERENCE_ON = 4;
    localparam int ACSC_S_WATCHDOG_OSC_POWER_DOWN = 3;
    localparam logic [1:0] ACSC_CLMP_REPORT = 2'h0;
    localparam logic [1:0] ACSC_CLMP_FORCE = 2'h1;
    localparam logic [1:0] ACSC_CLMP_AUTO = 2'h2;
    localparam logic [1:0] ACSC_CLMP_LATCH = 2'h3;
    localparam logic [3:0] ACSC_AVG_TAG = 4'hf;
    localparam int ACSC_WDT_LIMIT_DEF = 65535;
    localparam int ACSC_WDG_PULSE_NS = 1000;
    localparam int ACSC_CLK_NS = 40;
    localparam int ACSC_WDG_PULSE_CYC = (ACSC_WDG_PULSE_NS + ACSC_CLK_NS - 1) / ACSC_CLK_NS;
    // one sample from the converter, with its channel tag
    typedef struct packed {
        logic valid;
        logic [3:0] tag;
        logic [11:0] data;
    } acsc_sample_t;
endpackage

// File: rtl/acsc_top.sv
/*
  acsc_top: alarm output config, gate clamp control, average monitor and
  software shutdown, reached over apb.
  assumes alarm trip/clear inputs, samples and mode levels are on pclk.
*/
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module acsc_top
    import acsc_pkg::*;
#(
    parameter int WDT_LIMIT = ACSC_WDT_LIMIT_DEF
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire acsc_sample_t adc_sample,
    input wire logic lut_stream_mode,
    input wire logic message_mode,
    input wire logic [1:0] alarm_trip,
    input wire logic [1:0] alarm_gone,
    input wire logic wdt_kick,
    output acsc_sample_t fifo_push,
    output logic [1:0] gate_clamp,
    output logic alarm_out,
    output logic alarm_oe,
    output logic ch2_die_sensor_sel,
    output logic ch2_current_alarm_en,
    output logic full_power_down,
    output logic reference_on,
    output logic watchdog_osc_power_down,
    output logic sections_power_down
);
    logic [10:0] cfg_q;
    logic [5:0] shut_q;
    logic raw_mon_q;
    logic [1:0] flag_q;
    logic [1:0] held_q;
    logic [13:0] avg_q;
    logic [15:0] wdt_q;
    logic [4:0] wpulse_q;
    logic [31:0] prdata_q;
    acsc_sample_t push_q;
    logic alarm_out_q, alarm_oe_q;
    logic [1:0] clamp_q;

    // apb decode, zero wait states
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_cfg = paddr == ACSC_OFF_ALARM_CFG;
    wire hit_shut = paddr == ACSC_OFF_SHUTDOWN;
    wire hit_flag = paddr == ACSC_OFF_FLAGS;
    wire hit_mon = paddr == ACSC_OFF_MON_CTRL;
    wire mapped = hit_cfg || hit_shut || hit_flag || hit_mon;
    wire pd = shut_q[ACSC_S_FULL_POWER_DOWN];
    // full power down: only the shutdown register is heard
    wire blocked = pd && !hit_shut;
    wire wr_cfg = wr && hit_cfg && !blocked;
    wire wr_shut = wr && hit_shut;
    wire wr_mon = wr && hit_mon && !blocked;
    wire rd_flag = rd && hit_flag && !blocked;
    wire err = acc && (!mapped || blocked);

    // config fields
    wire [1:0] mode1 = cfg_q[ACSC_B_CLMP1 +: 2];
    wire [1:0] mode2 = cfg_q[ACSC_B_CLMP2 +: 2];
    wire [1:0] mode [2];
    assign mode[0] = mode1;
    assign mode[1] = mode2;
    wire avg_en = cfg_q[ACSC_B_AVERAGE_MONITOR_EN];
    wire die2 = cfg_q[ACSC_B_DIE2];
    wire comp = cfg_q[ACSC_B_COMP];
    wire pol_low = cfg_q[ACSC_B_POL];
    wire open_drn = cfg_q[ACSC_B_OPEN];
    // ch2 current trip left unmasked here; the die sensor masking is applied later, in the clamp and latch paths only
    wire [1:0] trip = alarm_trip & {1'b1, 1'b1};

    // hysteresis in lsbs, only reported in the monitor control readback
    wire [6:0] hyst_lsb = 7'h08 << cfg_q[ACSC_B_HYST +: 2];

    // average monitor running only outside streaming/message modes
    wire avg_run = avg_en && !raw_mon_q && !lut_stream_mode && !message_mode && !pd;
    wire [13:0] avg_d = avg_q + 14'({2'h0, adc_sample.data, 2'h0} >> 2) - (avg_q >> 2);

    // incoming config write, low eleven bits of pwdata kept as they are
    wire [10:0] cfg_wr = pwdata[10:0] & ACSC_CFG_MASK;

    // configuration register; hardware rewrites 11 to 01 on trip
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_q <= ACSC_CFG_RESET[10:0];
        else if (wdt_q == 16'(WDT_LIMIT))
            cfg_q <= ACSC_CFG_RESET[10:0];
        else
        begin
            cfg_q <= wr_cfg ? cfg_wr : cfg_q;
            // trip wins over a simultaneous write of the field
            if (trip[0] && mode1 == ACSC_CLMP_LATCH)
                cfg_q[ACSC_B_CLMP1 +: 2] <= ACSC_CLMP_FORCE;
            if (trip[1] && !die2 && mode2 == ACSC_CLMP_LATCH)
                cfg_q[ACSC_B_CLMP2 +: 2] <= ACSC_CLMP_FORCE;
        end
    end

    // shutdown register, low six bits only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shut_q <= ACSC_SHUT_RESET;
        else if (wr_shut)
            shut_q <= pwdata[5:0];
    end

    // raw monitor enable refused while averaging is on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_mon_q <= 1'b0;
        else if (wr_cfg && cfg_wr[ACSC_B_AVERAGE_MONITOR_EN])
            raw_mon_q <= 1'b0;
        else if (wr_mon)
            raw_mon_q <= pwdata[0] && !avg_en;
    end

    // sticky alarm flags; a trip wins over the read clear
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            wire tr = trip[g] && !(g == 1 && die2);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    flag_q[g] <= 1'b0;
                else if (trip[g])
                    flag_q[g] <= 1'b1;
                else if (rd_flag)
                    flag_q[g] <= 1'b0;
            end
            // clamp hold for mode 10; mode 11 latches through the config rewrite to 01
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    held_q[g] <= 1'b0;
                else if (mode[g] == ACSC_CLMP_REPORT)
                    held_q[g] <= 1'b0;
                else if (tr)
                    held_q[g] <= 1'b1;
                else if (mode[g] == ACSC_CLMP_AUTO && alarm_gone[g])
                    held_q[g] <= 1'b0;
                else if (mode[g] == ACSC_CLMP_LATCH)
                    held_q[g] <= 1'b0;
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    clamp_q[g] <= 1'b0;
                else
                    clamp_q[g] <= mode[g] == ACSC_CLMP_FORCE || (held_q[g] && mode[g] != ACSC_CLMP_LATCH) ||
                                  (tr && mode[g] != ACSC_CLMP_REPORT);
            end
        end
    endgenerate

    // tracking average and tagged push into the fifo
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            avg_q <= 14'h0000;
            push_q <= '0;
        end
        else
        begin
            push_q.valid <= avg_run && adc_sample.valid;
            push_q.tag <= ACSC_AVG_TAG;
            push_q.data <= avg_d[13:2];
            if (avg_run && adc_sample.valid)
                avg_q <= avg_d;
        end
    end

    // watchdog counter and its alarm pulse
    wire wdt_run = !shut_q[ACSC_S_WATCHDOG_OSC_POWER_DOWN] && !pd;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_q <= 16'h0000;
        else if (!wdt_run || wdt_kick || wdt_q == 16'(WDT_LIMIT))
            wdt_q <= 16'h0000;
        else
            wdt_q <= wdt_q + 16'h0001;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wpulse_q <= 5'h00;
        else if (wdt_run && wdt_q == 16'(WDT_LIMIT))
            wpulse_q <= 5'(ACSC_WDG_PULSE_CYC);
        else if (wpulse_q != 5'h00)
            wpulse_q <= wpulse_q - 5'h01;
    end

    // alarm level: comparator follows trips, interrupt holds to flag read
    logic int_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_q <= 1'b0;
        else if (|trip)
            int_q <= 1'b1;
        else if (rd_flag)
            int_q <= 1'b0;
    end
    wire act = (comp ? (|held_q || |trip) : int_q) || wpulse_q != 5'h00;
    wire lvl = act ^ pol_low;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_out_q <= 1'b0;
            alarm_oe_q <= 1'b1;
        end
        else
        begin
            alarm_out_q <= open_drn ? 1'b0 : lvl;
            alarm_oe_q <= open_drn ? !lvl : 1'b1;
        end
    end

    // read data mux
    wire [31:0] rd_mux = hit_cfg ? {21'h0, cfg_q & ~11'h400} :
                         hit_flag ? {30'h0, flag_q} :
                         hit_mon ? {25'h0, hyst_lsb} << 1 | {31'h0, raw_mon_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata_q <= rd_mux;
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = err;
    assign fifo_push = push_q;
    assign gate_clamp = clamp_q;
    assign alarm_out = alarm_out_q;
    assign alarm_oe = alarm_oe_q;
    assign ch2_die_sensor_sel = die2;
    assign ch2_current_alarm_en = !die2;
    assign full_power_down = pd;
    assign sections_power_down = pd;
    assign reference_on = shut_q[ACSC_S_FORCE_REFERENCE_ON] && !pd;
    assign watchdog_osc_power_down = shut_q[ACSC_S_WATCHDOG_OSC_POWER_DOWN] || pd;

    // assertions
    property p_latch_rewrite;
        @(posedge pclk) disable iff (!presetn)
        (trip[0] && mode1 == ACSC_CLMP_LATCH && wdt_q != 16'(WDT_LIMIT)) |=> mode1 == ACSC_CLMP_FORCE;
    endproperty
    a_latch_rewrite: assert property (p_latch_rewrite) else $error("latched clamp not rewritten");
    property p_force_clamp;
        @(posedge pclk) disable iff (!presetn)
        mode1 == ACSC_CLMP_FORCE |=> gate_clamp[0];
    endproperty
    a_force_clamp: assert property (p_force_clamp) else $error("forced clamp missing");
    property p_report_noclamp;
        @(posedge pclk) disable iff (!presetn)
        $past(mode1) == ACSC_CLMP_REPORT && mode1 == ACSC_CLMP_REPORT |=> !gate_clamp[0] || mode1 != ACSC_CLMP_REPORT;
    endproperty
    a_report_noclamp: assert property (p_report_noclamp) else $error("report mode clamped");
    property p_exclusive;
        @(posedge pclk) disable iff (!presetn)
        !(raw_mon_q && avg_run);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both monitors active");
    property p_pause;
        @(posedge pclk) disable iff (!presetn)
        (lut_stream_mode || message_mode) |=> !fifo_push.valid;
    endproperty
    a_pause: assert property (p_pause) else $error("average pushed while paused");
    property p_tag;
        @(posedge pclk) disable iff (!presetn)
        fifo_push.valid |-> fifo_push.tag == ACSC_AVG_TAG;
    endproperty
    a_tag: assert property (p_tag) else $error("average tag wrong");
    property p_pd_block;
        @(posedge pclk) disable iff (!presetn)
        (pd && wr && hit_cfg) |=> $stable(cfg_q) || mode1 == ACSC_CLMP_FORCE || mode2 == ACSC_CLMP_FORCE;
    endproperty
    a_pd_block: assert property (p_pd_block) else $error("write heard in power down");
    property p_int_hold;
        @(posedge pclk) disable iff (!presetn)
        (!comp && int_q && !rd_flag) |=> int_q;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");
    property p_ref;
        @(posedge pclk) disable iff (!presetn)
        pd |-> !reference_on && sections_power_down;
    endproperty
    a_ref: assert property (p_ref) else $error("power down not overriding");
endmodule
`default_nettype wire

// File: sim/acsc_alarm_line.sv
/*
  acsc_alarm_line: board-side model of the alarm pin as the host sees it.
  assumes a pull-up on the wire, so a released open-drain pin reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module acsc_alarm_line (
    input wire logic alarm_out,
    input wire logic alarm_oe,
    output logic alarm_wire
);
    // released pin floats to the pull-up, never to the last value
    assign alarm_wire = alarm_oe ? alarm_out : 1'b1;
endmodule
`default_nettype wire

// File: sim/alarm_clamp_and_shutdown_control_bench.sv
/*
  alarm_clamp_and_shutdown_control_bench: self-checking bench for acsc_top.
  assumes zero-wait apb slave and a short watchdog limit of 50 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module alarm_clamp_and_shutdown_control_bench
    import acsc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    acsc_sample_t adc_sample, fifo_push, got;
    logic lut_stream_mode, message_mode, wdt_kick, kick_en;
    logic [1:0] alarm_trip, alarm_gone, gate_clamp;
    logic alarm_out, alarm_oe, alarm_wire, die_sel, cur_en, fpd, ref_on, wdg_pd, sec_pd;
    int fails, num_checks;

    acsc_top #(.WDT_LIMIT(50)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_sample(adc_sample), .lut_stream_mode(lut_stream_mode),
        .message_mode(message_mode), .alarm_trip(alarm_trip), .alarm_gone(alarm_gone),
        .wdt_kick(wdt_kick), .fifo_push(fifo_push), .gate_clamp(gate_clamp), .alarm_out(alarm_out),
        .alarm_oe(alarm_oe), .ch2_die_sensor_sel(die_sel), .ch2_current_alarm_en(cur_en),
        .full_power_down(fpd), .reference_on(ref_on), .watchdog_osc_power_down(wdg_pd),
        .sections_power_down(sec_pd));
    acsc_alarm_line line (.alarm_out(alarm_out), .alarm_oe(alarm_oe), .alarm_wire(alarm_wire));

    // free-running clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // watchdog kicks every other cycle unless a scenario starves it
    always @(posedge pclk)
        wdt_kick <= kick_en && !wdt_kick;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            chk("pready", 1, 0);
            tally_and_finish();
        end
        rdata = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // registered outputs follow the write one edge later
        @(posedge pclk);
        #1;
    endtask

    // trip or clear pulse on one channel, then let registers settle
    task automatic pulse(input logic trip, input int ch);
        @(posedge pclk);
        if (trip)
            alarm_trip[ch] <= 1'b1;
        else
            alarm_gone[ch] <= 1'b1;
        @(posedge pclk);
        alarm_trip <= 2'b00;
        alarm_gone <= 2'b00;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic push_sample(input logic lut, input logic msg);
        @(posedge pclk);
        lut_stream_mode <= lut;
        message_mode <= msg;
        @(posedge pclk);
        adc_sample <= '{1'b1, 4'h2, 12'h400};
        @(posedge pclk);
        adc_sample.valid <= 1'b0;
        #1;
        got = fifo_push;
    endtask

    task automatic t_reset_and_map();
        chk("alarm_oe idle", 1, alarm_oe);
        chk("alarm_out idle", 0, alarm_out);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'hffff_0700);
        apb(1'b0, ACSC_OFF_ALARM_CFG, 32'h0);
        chk("cfg readback", 32'h300, rdata);
        chk("die sensor sel", 1, die_sel);
        chk("ch2 current alarm", 0, cur_en);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h0);
        chk("ch2 current alarm", 1, cur_en);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 1, last_err);
    endtask

    task automatic t_hyst();
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, ACSC_OFF_ALARM_CFG, 32'(c) << 6);
            apb(1'b0, ACSC_OFF_MON_CTRL, 32'h0);
            chk("hysteresis", (32'd8 << c) << 1, rdata & 32'hfe);
        end
    endtask

    task automatic t_clamp();
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h4);
        chk("force clamp", 2'b01, gate_clamp);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h8);
        chk("auto idle", 2'b00, gate_clamp);
        pulse(1'b1, 0);
        chk("auto clamp", 2'b01, gate_clamp);
        pulse(1'b0, 0);
        chk("auto release", 2'b00, gate_clamp);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h30);
        pulse(1'b1, 1);
        chk("latch clamp", 2'b10, gate_clamp);
        apb(1'b0, ACSC_OFF_ALARM_CFG, 32'h0);
        chk("latch rewrite", 32'h10, rdata);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h30);
        chk("latch release", 2'b00, gate_clamp);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h0);
        apb(1'b0, ACSC_OFF_FLAGS, 32'h0);
        pulse(1'b1, 1);
        chk("report no clamp", 2'b00, gate_clamp);
        apb(1'b0, ACSC_OFF_FLAGS, 32'h0);
        chk("report flag", 32'h2, rdata & 32'h3);
    endtask

    task automatic t_alarm();
        repeat (2) @(posedge pclk);
        #1;
        chk("int idle", 0, alarm_wire);
        pulse(1'b1, 0);
        repeat (5) @(posedge pclk);
        #1;
        chk("int held", 1, alarm_wire);
        apb(1'b0, ACSC_OFF_FLAGS, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk("int cleared", 0, alarm_wire);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h3);
        chk("od idle oe", 0, alarm_oe);
        pulse(1'b1, 0);
        chk("od active low", 0, alarm_wire);
        chk("od active oe", 1, alarm_oe);
        apb(1'b0, ACSC_OFF_FLAGS, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        chk("od released", 1, alarm_wire);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h108);
        pulse(1'b1, 0);
        chk("comp active", 1, alarm_wire);
        pulse(1'b0, 0);
        chk("comp follows", 0, alarm_wire);
        apb(1'b0, ACSC_OFF_FLAGS, 32'h0);
    endtask

    task automatic t_shutdown();
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h0);
        apb(1'b1, ACSC_OFF_SHUTDOWN, 32'h20);
        chk("full pd", 1, fpd);
        chk("sections pd", 1, sec_pd);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h4);
        chk("pd refused", 1, last_err);
        apb(1'b1, ACSC_OFF_SHUTDOWN, 32'hffc0);
        chk("full pd exit", 0, fpd);
        chk("high bits ignored", 0, {ref_on, wdg_pd, sec_pd});
        chk("write ignored", 2'b00, gate_clamp);
        apb(1'b1, ACSC_OFF_SHUTDOWN, 32'h18);
        chk("force ref", 1, ref_on);
        chk("wdg osc pd", 1, wdg_pd);
        apb(1'b0, ACSC_OFF_SHUTDOWN, 32'h0);
        chk("shutdown reads", 0, rdata);
        apb(1'b1, ACSC_OFF_SHUTDOWN, 32'h0);
    endtask

    task automatic t_average();
        apb(1'b1, ACSC_OFF_MON_CTRL, 32'h1);
        apb(1'b0, ACSC_OFF_MON_CTRL, 32'h0);
        chk("raw mon on", 1, rdata[0]);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h400);
        apb(1'b0, ACSC_OFF_MON_CTRL, 32'h0);
        chk("raw mon cleared", 0, rdata[0]);
        push_sample(1'b0, 1'b0);
        chk("avg push", 1, got.valid);
        chk("avg tag", ACSC_AVG_TAG, got.tag);
        chk("avg data", 12'h100, got.data);
        push_sample(1'b1, 1'b0);
        chk("avg lut pause", 0, got.valid);
        push_sample(1'b0, 1'b1);
        chk("avg msg pause", 0, got.valid);
        push_sample(1'b0, 1'b0);
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h0);
    endtask

    task automatic t_watchdog();
        int n;
        int h;
        apb(1'b1, ACSC_OFF_ALARM_CFG, 32'h100);
        @(posedge pclk);
        kick_en <= 1'b0;
        n = 0;
        h = 0;
        while (alarm_out !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200)
        begin
            chk("wdg pulse", 1, 0);
            tally_and_finish();
        end
        kick_en <= 1'b1;
        while (alarm_out === 1'b1 && h < 100)
        begin
            @(posedge pclk);
            h++;
        end
        chk("wdg pulse len", ACSC_WDG_PULSE_CYC, h);
        apb(1'b0, ACSC_OFF_ALARM_CFG, 32'h0);
        chk("wdg cfg reset", 0, rdata);
    endtask

    // reset, then scenarios in turn
    initial
    begin
        fails = 0;
        num_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        adc_sample = '0;
        {lut_stream_mode, message_mode, wdt_kick} = '0;
        alarm_trip = 2'b00;
        alarm_gone = 2'b00;
        kick_en = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset_and_map();
        t_hyst();
        t_clamp();
        t_alarm();
        t_shutdown();
        t_average();
        t_watchdog();
        tally_and_finish();
    end
endmodule
`default_nettype wire
